/* verilog/irq_regs_pkg.sv */
/*
 * Constants, field layouts and carrier types for the interrupt control and
 * status register slice.
 * Assumes an AHB-Lite bus of 32-bit data on one clock shared with the CPU
 * core and all interrupt sources.
 */
`default_nettype none
package irq_regs_pkg;
   // ************************************************************
   // Register byte addresses
   // ************************************************************
   localparam logic [7:0] CORE_CONTROL_ADDR = 8'h00;
   localparam logic [7:0] ALU_STATUS_ADDR = 8'h04;
   localparam logic [7:0] INT_CONTROL_ONE_ADDR = 8'h08;
   localparam logic [7:0] INT_CONTROL_TWO_ADDR = 8'h0c;
   localparam logic [7:0] FLAGS_ZERO_ADDR = 8'h10;
   localparam logic [7:0] FLAGS_ONE_ADDR = 8'h14;
   localparam logic [7:0] TRAP_STATUS_ADDR = 8'h18;
   localparam logic [7:0] TRAP_MASK_ADDR = 8'h1c;
   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int PRIO_MSB_BIT = 3;
   localparam int PSV_BIT = 2;
   localparam int PRIO_FIELD_LO = 5;
   localparam int NEST_DIS_BIT = 15;
   localparam int ARITH_BIT = 4;
   localparam int ADDR_BIT = 3;
   localparam int STACK_BIT = 2;
   localparam int OSC_BIT = 1;
   localparam int ALT_VEC_BIT = 15;
   localparam int DEFER_BIT = 14;
   // ************************************************************
   // Write masks of implemented bits
   // ************************************************************
   localparam logic [15:0] INT_ONE_MASK = 16'h801e;
   localparam logic [15:0] INT_TWO_WMASK = 16'h801f;
   localparam logic [15:0] FLAGS_ZERO_MASK = 16'h7fff;
   localparam logic [15:0] FLAGS_ONE_MASK = 16'hff1f;
   localparam logic [15:0] ALU_PRIO_MASK = 16'h00e0;
   // ************************************************************
   // Reset values
   // ************************************************************
   localparam logic PSV_RESET = 1'b1;
   localparam logic [15:0] REG_RESET = 16'h0000;
   localparam logic [3:0] TRAP_RESET = 4'h0;
   // ************************************************************
   // Carriers
   // ************************************************************
   typedef struct packed {
      logic arith;
      logic addr;
      logic stack;
      logic osc;
   } trap_evt_type;
   typedef struct packed {
      logic [15:0] flags_zero;
      logic [15:0] flags_one;
   } req_evt_type;
endpackage
`default_nettype wire

/* verilog/irq_ctrl_status_regs.sv */
/*
 * Interrupt control and status registers with an AHB-Lite slave port.
 * Assumes requests, trap events and core status arrive as one-cycle pulses
 * or levels from logic on mclk_i; the slave answers with no wait states.
 */
`timescale 1ns/1ns
`default_nettype none
module irq_ctrl_status_regs
   import irq_regs_pkg::*;
(
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   // AHB-Lite slave
   input wire logic hsel_i,
   input wire logic [7:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic hready_i,
   input wire logic [31:0] hwdata_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   // Core side
   input wire logic prio_msb_set_i,
   input wire logic prio_msb_clr_i,
   input wire logic psv_i,
   input wire logic defer_active_i,
   input wire trap_evt_type trap_evt_i,
   input wire req_evt_type req_evt_i,
   output logic [3:0] cpu_prio_level_o,
   output logic nesting_disable_o,
   output logic alt_vector_select_o,
   output logic [4:0] ext_edge_polarity_o,
   output logic [15:0] request_flags_zero_o,
   output logic [15:0] request_flags_one_o,
   output logic trap_irq_o
);
   // ************************************************************
   // Bus address phase capture
   // ************************************************************
   logic wr_pend_ff;
   logic [7:0] wr_addr_ff;
   logic rd_go;
   logic wr_go;
   logic [15:0] wd;
   logic [15:0] rd_val;
   logic priority_level_msb_ff;
   logic program_space_view_ff;
   logic [2:0] priority_level_low_field_ff;
   logic nesting_disable_ff;
   logic [3:0] trap_flags_ff;
   logic [3:0] trap_mask_ff;
   logic alt_vector_select_ff;
   logic irq_defer_active_ff;
   logic [4:0] ext_edge_polarity_ff;
   logic [15:0] request_flags_zero_ff;
   logic [15:0] request_flags_one_ff;
   logic [31:0] hrdata_ff;
   logic trap_irq_ff;
   logic [3:0] trap_evt;
   logic xfer_ok;
   logic wr_core_ctl;
   logic wr_alu_stat;
   logic wr_ctl_one;
   logic wr_ctl_two;
   logic wr_flags_zero;
   logic wr_flags_one;
   logic wr_trap_stat;
   logic wr_trap_mask;
   logic [15:0] core_ctl_img;
   logic [15:0] alu_stat_img;
   logic [15:0] ctl_one_img;
   logic [15:0] ctl_two_img;
   logic [15:0] trap_stat_img;
   logic [15:0] trap_mask_img;
   logic hreadyout_ff;
   logic hresp_ff;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
      hit = (a == r);
   endfunction

   function automatic logic flag_next(input logic cur, input logic set,
                                      input logic wr, input logic d);
      flag_next = set | (wr ? d : cur);
   endfunction

   assign xfer_ok = hsel_i && hready_i && htrans_i[1];
   assign rd_go = xfer_ok && !hwrite_i;
   assign wr_go = wr_pend_ff;
   assign wd = hwdata_i[15:0];
   assign trap_evt = trap_evt_i;

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         wr_pend_ff <= 1'b0;
         wr_addr_ff <= 8'h00;
      end else begin
         wr_pend_ff <= xfer_ok && hwrite_i;
         wr_addr_ff <= haddr_i;
      end
   end

   // ************************************************************
   // Write strobes, one per register, in the data phase
   // ************************************************************
   assign wr_core_ctl = wr_go && hit(wr_addr_ff, CORE_CONTROL_ADDR);
   assign wr_alu_stat = wr_go && hit(wr_addr_ff, ALU_STATUS_ADDR);
   assign wr_ctl_one = wr_go && hit(wr_addr_ff, INT_CONTROL_ONE_ADDR);
   assign wr_ctl_two = wr_go && hit(wr_addr_ff, INT_CONTROL_TWO_ADDR);
   assign wr_flags_zero = wr_go && hit(wr_addr_ff, FLAGS_ZERO_ADDR);
   assign wr_flags_one = wr_go && hit(wr_addr_ff, FLAGS_ONE_ADDR);
   assign wr_trap_stat = wr_go && hit(wr_addr_ff, TRAP_STATUS_ADDR);
   assign wr_trap_mask = wr_go && hit(wr_addr_ff, TRAP_MASK_ADDR);

   // ************************************************************
   // Bus response, never waits, always OKAY
   // ************************************************************
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         hreadyout_ff <= 1'b1;
         hresp_ff <= 1'b0;
      end else begin
         hreadyout_ff <= 1'b1;
         hresp_ff <= 1'b0;
      end
   end

   // ************************************************************
   // Core control word and ALU status priority field
   // ************************************************************
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         priority_level_msb_ff <= 1'b0;
      end else if (prio_msb_set_i) begin
         priority_level_msb_ff <= 1'b1;
      end else if (prio_msb_clr_i ||
                   (wr_core_ctl && !wd[PRIO_MSB_BIT])) begin
         priority_level_msb_ff <= 1'b0;
      end
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         program_space_view_ff <= PSV_RESET;
      end else begin
         program_space_view_ff <= psv_i;
      end
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         priority_level_low_field_ff <= 3'h0;
      end else if (wr_alu_stat && !nesting_disable_ff) begin
         priority_level_low_field_ff <= wd[PRIO_FIELD_LO +: 3];
      end
   end

   // ************************************************************
   // Interrupt control one
   // ************************************************************
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         nesting_disable_ff <= 1'b0;
      end else if (wr_ctl_one) begin
         nesting_disable_ff <= wd[NEST_DIS_BIT];
      end
   end

   // Set wins over a software write in the same cycle
   generate
      for (genvar t = 0; t < 4; t++) begin : g_trap
         always_ff @(posedge mclk_i or posedge rst_i) begin
            if (rst_i) begin
               trap_flags_ff[t] <= TRAP_RESET[t];
            end else if (trap_evt[t]) begin
               trap_flags_ff[t] <= 1'b1;
            end else if (wr_ctl_one) begin
               trap_flags_ff[t] <= wd[OSC_BIT + t];
            end else if (wr_trap_stat && wd[t]) begin
               trap_flags_ff[t] <= 1'b0;
            end
         end
      end
   endgenerate

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         trap_mask_ff <= TRAP_RESET;
      end else if (wr_trap_mask) begin
         trap_mask_ff <= wd[3:0];
      end
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         trap_irq_ff <= 1'b0;
      end else begin
         trap_irq_ff <= |(trap_flags_ff & trap_mask_ff);
      end
   end

   // ************************************************************
   // Interrupt control two
   // ************************************************************
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         alt_vector_select_ff <= 1'b0;
         ext_edge_polarity_ff <= 5'h00;
      end else if (wr_ctl_two) begin
         alt_vector_select_ff <= wd[ALT_VEC_BIT];
         ext_edge_polarity_ff <= wd[4:0];
      end
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         irq_defer_active_ff <= 1'b0;
      end else begin
         irq_defer_active_ff <= defer_active_i;
      end
   end

   // ************************************************************
   // Request flags, set wins over clear
   // ************************************************************
   generate
      for (genvar b = 0; b < 16; b++) begin : g_flags
         always_ff @(posedge mclk_i or posedge rst_i) begin
            if (rst_i) begin
               request_flags_zero_ff[b] <= REG_RESET[b];
            end else begin
               request_flags_zero_ff[b] <= FLAGS_ZERO_MASK[b] &
                  flag_next(request_flags_zero_ff[b],
                            req_evt_i.flags_zero[b],
                            wr_flags_zero, wd[b]);
            end
         end

         always_ff @(posedge mclk_i or posedge rst_i) begin
            if (rst_i) begin
               request_flags_one_ff[b] <= REG_RESET[b];
            end else begin
               request_flags_one_ff[b] <= FLAGS_ONE_MASK[b] &
                  flag_next(request_flags_one_ff[b],
                            req_evt_i.flags_one[b],
                            wr_flags_one, wd[b]);
            end
         end
      end
   endgenerate

   // ************************************************************
   // Read images of the control registers
   // ************************************************************
   always_comb begin
      core_ctl_img = 16'h0000;
      core_ctl_img[PRIO_MSB_BIT] = priority_level_msb_ff;
      core_ctl_img[PSV_BIT] = program_space_view_ff;
   end

   always_comb begin
      alu_stat_img = 16'h0000;
      alu_stat_img[PRIO_FIELD_LO +: 3] = priority_level_low_field_ff;
   end

   always_comb begin
      ctl_one_img = 16'h0000;
      ctl_one_img[NEST_DIS_BIT] = nesting_disable_ff;
      ctl_one_img[ADDR_BIT+1:OSC_BIT] = trap_flags_ff;
   end

   always_comb begin
      ctl_two_img = 16'h0000;
      ctl_two_img[ALT_VEC_BIT] = alt_vector_select_ff;
      ctl_two_img[DEFER_BIT] = irq_defer_active_ff;
      ctl_two_img[4:0] = ext_edge_polarity_ff;
   end

   always_comb begin
      trap_stat_img = 16'h0000;
      trap_stat_img[3:0] = trap_flags_ff;
   end

   always_comb begin
      trap_mask_img = 16'h0000;
      trap_mask_img[3:0] = trap_mask_ff;
   end

   // ************************************************************
   // Read mux, unmapped reads zero
   // ************************************************************
   always_comb begin
      rd_val = 16'h0000;
      if (hit(haddr_i, CORE_CONTROL_ADDR)) begin
         rd_val = core_ctl_img;
      end else if (hit(haddr_i, ALU_STATUS_ADDR)) begin
         rd_val = alu_stat_img;
      end else if (hit(haddr_i, INT_CONTROL_ONE_ADDR)) begin
         rd_val = ctl_one_img;
      end else if (hit(haddr_i, INT_CONTROL_TWO_ADDR)) begin
         rd_val = ctl_two_img;
      end else if (hit(haddr_i, FLAGS_ZERO_ADDR)) begin
         rd_val = request_flags_zero_ff;
      end else if (hit(haddr_i, FLAGS_ONE_ADDR)) begin
         rd_val = request_flags_one_ff;
      end else if (hit(haddr_i, TRAP_STATUS_ADDR)) begin
         rd_val = trap_stat_img;
      end else if (hit(haddr_i, TRAP_MASK_ADDR)) begin
         rd_val = trap_mask_img;
      end
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         hrdata_ff <= 32'h0000_0000;
      end else if (rd_go) begin
         hrdata_ff <= {16'h0000, rd_val};
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   assign hrdata_o = hrdata_ff;
   assign hreadyout_o = hreadyout_ff;
   assign hresp_o = hresp_ff;
   assign cpu_prio_level_o = {priority_level_msb_ff,
                              priority_level_low_field_ff};
   assign nesting_disable_o = nesting_disable_ff;
   assign alt_vector_select_o = alt_vector_select_ff;
   assign ext_edge_polarity_o = ext_edge_polarity_ff;
   assign request_flags_zero_o = request_flags_zero_ff;
   assign request_flags_one_o = request_flags_one_ff;
   assign trap_irq_o = trap_irq_ff;
endmodule // irq_ctrl_status_regs
`default_nettype wire

/* test/irq_regs_monitor.sv */
/* Port checker of the register slice.
   Bound to every irq_ctrl_status_regs instance; one clock domain. */
`timescale 1ns/1ns
`default_nettype none
module irq_regs_monitor
   import irq_regs_pkg::*;
(
   // Clock, reset, bus
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic hsel_i,
   input wire logic [7:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [31:0] hrdata_o,
   // Core side
   input wire logic prio_msb_set_i,
   input wire logic prio_msb_clr_i,
   input wire req_evt_type req_evt_i,
   input wire logic [3:0] cpu_prio_level_o,
   input wire logic nesting_disable_o,
   input wire logic alt_vector_select_o,
   input wire logic [4:0] ext_edge_polarity_o,
   input wire logic [15:0] request_flags_zero_o,
   input wire logic [15:0] request_flags_one_o
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   logic wr;
   assign wr = hsel_i & htrans_i[1] & hwrite_i;
   a_msb_set: assert property (prio_msb_set_i |=> cpu_prio_level_o[3])
      else $error("priority msb not set");
   a_msb_clear: assert property ($fell(cpu_prio_level_o[3]) |->
      $past(wr && haddr_i == 8'h00, 2) || $past(prio_msb_clr_i))
      else $error("msb cleared alone");
   a_field_write: assert property (!$stable(cpu_prio_level_o[2:0]) |->
      $past(wr && haddr_i == 8'h04, 2) && !$past(nesting_disable_o))
      else $error("priority field changed wrongly");
   a_flags_zero_set: assert property ((request_flags_zero_o |
      ~($past(req_evt_i.flags_zero) & FLAGS_ZERO_MASK)) == 16'hffff)
      else $error("flag zero not set");
   a_flags_one_set: assert property ((request_flags_one_o |
      ~($past(req_evt_i.flags_one) & FLAGS_ONE_MASK)) == 16'hffff)
      else $error("flag one not set");
   a_unused_read_zero: assert property (!request_flags_zero_o[15] &&
      request_flags_one_o[7:5] == 3'h0 && hrdata_o[31:16] == 16'h0000)
      else $error("unused bit set");
   a_nest_by_write: assert property (!$stable(nesting_disable_o) |->
      $past(wr && haddr_i == 8'h08, 2)) else $error("nesting changed");
   a_alt_by_write: assert property (!$stable(alt_vector_select_o) |->
      $past(wr && haddr_i == 8'h0c, 2)) else $error("vector changed");
   a_edge_by_write: assert property (!$stable(ext_edge_polarity_o) |->
      $past(wr && haddr_i == 8'h0c, 2)) else $error("polarity changed");
   c_msb: cover property (prio_msb_set_i);
   c_locked: cover property (wr && haddr_i == 8'h04 && nesting_disable_o);
   c_flag: cover property (|req_evt_i.flags_one);
endmodule // irq_regs_monitor
bind irq_ctrl_status_regs irq_regs_monitor irq_regs_monitor_i (.mclk_i,
   .rst_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hrdata_o,
   .prio_msb_set_i, .prio_msb_clr_i, .req_evt_i, .cpu_prio_level_o,
   .nesting_disable_o,
   .alt_vector_select_o, .ext_edge_polarity_o, .request_flags_zero_o,
   .request_flags_one_o);
`default_nettype wire

/* test/irq_source_model.sv */
/* Core and interrupt sources beside the slice.
   Assumes the bench raises fire_i for one cycle per event. */
`timescale 1ns/1ns
`default_nettype none
module irq_source_model
   import irq_regs_pkg::*;
(
   // Clock, reset, commands
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic fire_i,
   input wire trap_evt_type trap_cmd_i,
   input wire req_evt_type req_cmd_i,
   input wire logic prio_cmd_i,
   // Events to the slice
   output var trap_evt_type trap_evt_o,
   output var req_evt_type req_evt_o,
   output var logic prio_set_o
);
   // One-cycle event pulses
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         trap_evt_o <= '0;
         req_evt_o <= '0;
         prio_set_o <= 1'b0;
      end else begin
         trap_evt_o <= fire_i ? trap_cmd_i : '0;
         req_evt_o <= fire_i ? req_cmd_i : '0;
         prio_set_o <= fire_i & prio_cmd_i;
      end
   end
endmodule // irq_source_model
`default_nettype wire

/* test/tb_irq_ctrl_status_regs.sv */
/* Self-checking bench of the register slice.
   Assumes an AHB-Lite master with bounded waits on hready. */
`timescale 1ns/1ns
`default_nettype none
module tb_irq_ctrl_status_regs;
   import irq_regs_pkg::*;
   logic mclk_i = 1'b0, rst_i = 1'b1, hwrite = 1'b0, program_space_view = 1'b1;
   logic defer = 1'b0, fire = 1'b0, pcmd = 1'b0, clr = 1'b0;
   logic prio_set, hready, hresp, irq, nest, alt;
   logic [7:0] haddr = 8'h00;
   logic [1:0] htrans = 2'h0;
   logic [31:0] hwdata = 32'h0, hrdata, q;
   logic [3:0] level;
   logic [4:0] epol;
   logic [15:0] f0, f1;
   trap_evt_type tcmd = '0, tevt;
   req_evt_type rcmd = '0, revt;
   int mismatches = 0, total_checks = 0;
   irq_ctrl_status_regs irq_ctrl_status_regs_i (.mclk_i, .rst_i,
      .hsel_i(1'b1), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
      .hsize_i(3'h2), .hready_i(hready), .hwdata_i(hwdata), .hrdata_o(hrdata),
      .hreadyout_o(hready), .hresp_o(hresp), .prio_msb_set_i(prio_set),
      .prio_msb_clr_i(clr), .psv_i(program_space_view), .defer_active_i(defer),
      .trap_evt_i(tevt), .req_evt_i(revt), .cpu_prio_level_o(level),
      .nesting_disable_o(nest), .alt_vector_select_o(alt),
      .ext_edge_polarity_o(epol), .request_flags_zero_o(f0),
      .request_flags_one_o(f1), .trap_irq_o(irq));
   irq_source_model irq_source_model_i (.mclk_i, .rst_i, .fire_i(fire),
      .trap_cmd_i(tcmd), .req_cmd_i(rcmd), .prio_cmd_i(pcmd),
      .trap_evt_o(tevt), .req_evt_o(revt), .prio_set_o(prio_set));
   initial begin
      forever #50 mclk_i = ~mclk_i;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %0t got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic wait_ready;
      int n;
      n = 0;
      do begin
         @(posedge mclk_i);
         n++;
      end while (hready !== 1'b1 && n < 20);
      if (hready !== 1'b1) begin
         mismatches++;
         tally_and_finish;
      end
   endtask
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
      @(posedge mclk_i);
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      wait_ready;
      htrans <= 2'h0;
      hwdata <= d;
      wait_ready;
      q = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0);
      chk(q, exp);
   endtask
   task automatic pulse(input trap_evt_type t, input req_evt_type r,
                        input logic p);
      @(posedge mclk_i);
      fire <= 1'b1;
      tcmd <= t;
      rcmd <= r;
      pcmd <= p;
      @(posedge mclk_i);
      fire <= 1'b0;
   endtask
   initial begin
      repeat (16) @(posedge mclk_i);
      rst_i <= 1'b0;
      rd(8'h00, 32'h4);
      for (int i = 2; i < 6; i++) rd(8'(4 * i), 32'h0);
      wr(8'h08, 32'hffffffff);
      rd(8'h08, 32'h801e);
      chk(nest, 1'b1);
      wr(8'h08, 32'h0);
      wr(8'h0c, 32'hffffffff);
      defer <= 1'b1;
      rd(8'h0c, 32'hc01f);
      chk({alt, epol}, 6'h3f);
      defer <= 1'b0;
      program_space_view <= 1'b0;
      wr(8'h0c, 32'h0);
      rd(8'h0c, 32'h0);
      rd(8'h00, 32'h0);
      for (int i = 0; i < 4; i++) begin
         pulse(trap_evt_type'(4'h1 << i), '0, 1'b0);
         rd(8'h08, 32'h2 << i);
         wr(8'h08, 32'h0);
      end
      pulse(4'h8, '0, 1'b0);
      rd(8'h18, 32'h8);
      chk(irq, 1'b0);
      wr(8'h1c, 32'h8);
      rd(8'h1c, 32'h8);
      chk(irq, 1'b1);
      wr(8'h18, 32'h8);
      rd(8'h08, 32'h0);
      chk(irq, 1'b0);
      for (int i = 0; i < 16; i++) begin
         pulse('0, {16'h1 << i, 16'h1 << i}, 1'b0);
         rd(8'h10, (32'h1 << i) & 32'h7fff);
         rd(8'h14, (32'h1 << i) & 32'hff1f);
         wr(8'h10, 32'h0);
         wr(8'h14, 32'h0);
         rd(8'h10, 32'h0);
      end
      pulse('0, '0, 1'b1);
      rd(8'h00, 32'h8);
      wr(8'h04, 32'hffff);
      rd(8'h04, 32'he0);
      chk(level, 4'hf);
      wr(8'h08, 32'h8000);
      wr(8'h04, 32'h0);
      rd(8'h04, 32'he0);
      wr(8'h08, 32'h0);
      wr(8'h04, 32'h20);
      wr(8'h00, 32'h0);
      rd(8'h00, 32'h0);
      chk(level, 4'h1);
      pulse('0, '0, 1'b1);
      rd(8'h00, 32'h8);
      @(posedge mclk_i) clr <= 1'b1;
      @(posedge mclk_i) clr <= 1'b0;
      rd(8'h00, 32'h0);
      wr(8'h20, 32'hffffffff);
      rd(8'h20, 32'h0);
      chk(hresp, 1'b0);
      wr(8'h0c, 32'h8000);
      rst_i <= 1'b1;
      repeat (2) @(posedge mclk_i);
      rst_i <= 1'b0;
      rd(8'h0c, 32'h0);
      tally_and_finish;
   end
endmodule // tb_irq_ctrl_status_regs
`default_nettype wire
